// *** dv/sdmrb_ctrl_model.sv ***
// Controller-side pin driver for the SDRAM configuration block
`timescale 1ns/100ps
`default_nettype none
module sdmrb_ctrl_model
  import sdmrb_pkg::*;
(
  input wire logic i_clock,
  output sdmrb_pins_t o_pins
);
  localparam logic [3:0] CMD_CLOSE_ALL = 4'h2;
  logic [ADDR_W-1:0] pat = 13'h1555;
  initial o_pins = {4'hf, 2'h0, 13'h1555};
  // Deselected: lines keep toggling so no stale value looks valid
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_clock);
      #1 pat = ~pat;
      o_pins = {4'hf, pat[1:0], pat};
    end
  endtask
  task automatic drive(input logic [3:0] c, input logic [1:0] ba, input logic [ADDR_W-1:0] a);
    @(posedge i_clock);
    #1 o_pins = {c, ba, a};
  endtask
  task automatic refresh2;
    repeat (2) begin
      drive(CMD_REFRESH, 2'h0, pat);
      idle(1);
    end
  endtask
  // Banks closed first, upper bits low, then a settling gap
  task automatic load(input logic [1:0] ba, input logic [9:0] v);
    drive(CMD_CLOSE_ALL, 2'h0, 13'h0400);
    drive(CMD_LOAD, ba, {3'h0, v});
    idle(2);
  endtask
  // Only after both refreshes and both loads
  task automatic row_open;
    drive(CMD_ROW_OPEN, 2'h0, pat);
    idle(1);
  endtask
endmodule
`default_nettype wire

// *** dv/tb_sdmrb_core.sv ***
// Self-checking bench for the SDRAM configuration and burst logic
`timescale 1ns/100ps
`default_nettype none
module tb_sdmrb_core;
  import sdmrb_pkg::*;
  typedef struct packed {
    logic rd;
    logic [COL_W-1:0] col;
    logic [31:0] cyc;
  } sdmrb_exp_t;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  sdmrb_pins_t pins;
  logic [CFG_W-1:0] cfg, ext_cfg;
  logic loaded, std_mode, busy, oe_n;
  logic [COL_W-1:0] blen;
  logic [1:0] lat;
  sdmrb_beat_t rd, wr;
  int fails = 0;
  int total_checks = 0;
  logic [31:0] cyc = 0;
  logic [31:0] seed = 32'h77ba;
  sdmrb_exp_t pend[$];
  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) cyc <= cyc + 1;
  sdmrb_ctrl_model i_sdmrb_ctrl_model (.i_clock(i_clock), .o_pins(pins));
  sdmrb_core i_sdmrb_core (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_pins(pins),
    .o_cfg(cfg), .o_ext_cfg(ext_cfg), .o_cfg_loaded(loaded), .o_burst_len(blen),
    .o_cas_lat(lat), .o_std_mode(std_mode), .o_busy(busy), .o_rd(rd), .o_dq_oe_n(oe_n),
    .o_wr(wr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string msg);
    total_checks++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Notes the expected beats; the monitor below consumes them
  task automatic burst(input logic r, input logic [COL_W-1:0] s, input int len, input logic ilv,
                       input int q, input int n);
    logic [COL_W-1:0] m;
    logic [31:0] b;
    m = COL_W'(len - 1);
    i_sdmrb_ctrl_model.drive(r ? CMD_READ : CMD_WRITE, 2'h0, {3'h0, s});
    b = cyc;
    for (int k = 0; k < n; k++) begin
      pend.push_back({r, (s & ~m) | ((ilv ? s ^ COL_W'(k) : s + COL_W'(k)) & m),
                      32'(b + (r ? q : 1) + k)});
    end
  endtask
  task automatic cfg_load(input logic [9:0] v, input int len, input int q, input logic std);
    i_sdmrb_ctrl_model.load(BA_BASE, v);
    check(32'(cfg), {22'h0, v}, "base register");
    check(32'(loaded), 32'h1, "loaded flag");
    check(32'(blen), 32'(len), "burst length");
    check(32'(lat), 32'(q), "read latency");
    check(32'(std_mode), 32'(std), "operating mode");
  endtask
  always @(negedge i_clock) begin : mon
    sdmrb_exp_t e;
    if (!i_sys_rst) begin
      check(32'(oe_n), 32'(!rd.valid), "drive enable");
      if (rd.valid || wr.valid) begin
        if (pend.size() == 0) begin
          check(32'h1, 32'h0, "beat not expected");
        end else begin
          e = pend.pop_front();
          check(32'(rd.valid), 32'(e.rd), "beat kind");
          check(32'(e.rd ? rd.col : wr.col), 32'(e.col), "column");
          check(cyc, e.cyc, "beat timing");
        end
      end
    end
  end
  always @(posedge i_clock) begin
    if (cyc == 32'd6000) begin
      fails++;
      close_out();
    end
  end
  initial begin : main
    logic [9:0] v;
    int bl, q, len;
    logic ilv, wb;
    logic [COL_W-1:0] s;
    repeat (12) @(posedge i_clock);
    #1 i_sys_rst = 1'b0;
    i_sdmrb_ctrl_model.refresh2();
    burst(1'b1, 10'h005, 1, 1'b0, 1, 0);
    i_sdmrb_ctrl_model.idle(8);
    cfg_load(10'h022, 4, 2, 1'b1);
    i_sdmrb_ctrl_model.load(BA_EXT, 10'h000);
    i_sdmrb_ctrl_model.row_open();
    // Defined codes only in the random sweep
    for (int i = 0; i < 16; i++) begin
      bl = i % 4;
      ilv = 1'(i / 4);
      wb = 1'(i / 8);
      q = 1 + int'(rnd() % 3);
      s = 10'(rnd());
      len = 1 << bl;
      v = {wb, 2'h0, 3'(q), ilv, 3'(bl)};
      cfg_load(v, len, q, 1'b1);
      burst(1'b0, s, len, ilv, q, wb ? 1 : len);
      i_sdmrb_ctrl_model.idle(len + 1);
      burst(1'b1, s, len, ilv, q, len);
      i_sdmrb_ctrl_model.idle(len + q + 2);
    end
    // Full page from near the row end, cut short after six beats
    cfg_load(10'h027, 512, 2, 1'b1);
    burst(1'b0, 10'h1fd, 512, 1'b0, 2, 6);
    i_sdmrb_ctrl_model.idle(5);
    check(32'(busy), 32'h1, "page burst running");
    i_sdmrb_ctrl_model.drive(CMD_TERM, 2'h0, 13'h0);
    i_sdmrb_ctrl_model.idle(4);
    check(32'(busy), 32'h0, "page burst stopped");
    // Reserved codes on purpose, to see the chosen fallbacks
    cfg_load(10'h005, 1, 3, 1'b1);
    cfg_load(10'h02f, 1, 2, 1'b1);
    cfg_load(10'h0a2, 4, 2, 1'b0);
    burst(1'b1, 10'h003, 4, 1'b0, 2, 0);
    i_sdmrb_ctrl_model.idle(8);
    i_sdmrb_ctrl_model.load(BA_EXT, 10'h025);
    check(32'(ext_cfg), {17'h0, BA_EXT, 13'h025}, "extended register");
    i_sdmrb_ctrl_model.load(2'h1, 10'h3ff);
    check(32'(cfg), 32'h0a2, "base register held");
    check(32'(pend.size()), 32'h0, "beats missing");
    close_out();
  end
endmodule
`default_nettype wire

// *** hdl/sdmrb_col_gen.sv ***
// Column address of one burst beat, wrapped inside its aligned block
`timescale 1ns/100ps
`default_nettype none
module sdmrb_col_gen
  import sdmrb_pkg::*;
(
  input wire logic [COL_W-1:0] i_start,
  input wire logic [COL_W-1:0] i_cnt,
  input wire logic [COL_W-1:0] i_mask,
  input wire logic i_ilv,
  output logic [COL_W-1:0] o_col
);

  logic [COL_W-1:0] off;

  // Interleave xors the count in, sequential adds it
  assign off = i_ilv ? (i_start ^ i_cnt) : COL_W'(i_start + i_cnt);
  // Bits above the mask come from the start column and never move
  assign o_col = (i_start & ~i_mask) | (off & i_mask);

endmodule
`default_nettype wire

// *** hdl/sdmrb_core.sv ***
// Configuration register and burst sequencer of a quad-bank SDRAM
`timescale 1ns/100ps
`default_nettype none
module sdmrb_core
  import sdmrb_pkg::*;
#(
  parameter int PAGE_LEN = 512
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire sdmrb_pins_t i_pins,
  output logic [CFG_W-1:0] o_cfg,
  output logic [CFG_W-1:0] o_ext_cfg,
  output logic o_cfg_loaded,
  output logic [COL_W-1:0] o_burst_len,
  output logic [1:0] o_cas_lat,
  output logic o_std_mode,
  output logic o_busy,
  output sdmrb_beat_t o_rd,
  output logic o_dq_oe_n,
  output sdmrb_beat_t o_wr
);

  localparam logic [COL_W-1:0] PAGE_MASK = COL_W'(PAGE_LEN - 1);

  typedef struct packed {
    logic [CFG_W-1:0] cfg;
    logic [CFG_W-1:0] ext;
    logic loaded;
    logic [COL_W-1:0] blen;
    logic [1:0] lat;
    logic std;
    sdmrb_st_t st;
    logic busy;
    logic wr;
    logic page;
    logic [COL_W-1:0] cnt;
    logic [COL_W-1:0] start;
    logic [COL_W-1:0] bmask;
    sdmrb_beat_t p1;
    sdmrb_beat_t p2;
    sdmrb_beat_t rd;
    sdmrb_beat_t wb;
    logic dq_oe_n;
  } sdmrb_state_t;

  sdmrb_state_t q;
  sdmrb_state_t d;

  logic [3:0] cmd;
  logic rw_hit;
  logic wr_cmd;
  logic [COL_W-1:0] new_mask;
  logic [COL_W-1:0] g_start;
  logic [COL_W-1:0] g_cnt;
  logic [COL_W-1:0] g_mask;
  logic [COL_W-1:0] g_col;
  sdmrb_beat_t beat;
  sdmrb_beat_t rbeat;
  logic beat_wr;

  // Offset mask of a burst; reserved codes fall back to one location
  function automatic logic [COL_W-1:0] bl_mask(input logic [CFG_W-1:0] c);
    logic [COL_W-1:0] m;
    m = '0;
    unique case (c[BL_LSB +: BL_W])
      BL_2: m = 10'h001;
      BL_4: m = 10'h003;
      BL_8: m = 10'h007;
      BL_PAGE: m = c[BT_BIT] ? 10'h000 : PAGE_MASK;
      default: m = 10'h000;
    endcase
    return m;
  endfunction

  // Reserved latency codes behave as the slowest setting
  function automatic logic [1:0] lat_dec(input logic [CFG_W-1:0] c);
    logic [1:0] l;
    l = LAT_CYC_3;
    unique case (c[LAT_LSB +: LAT_W])
      LAT_1: l = LAT_CYC_1;
      LAT_2: l = LAT_CYC_2;
      LAT_3: l = LAT_CYC_3;
      default: l = LAT_CYC_3;
    endcase
    return l;
  endfunction

  assign cmd = {i_pins.cs_n, i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
  assign wr_cmd = (cmd == CMD_WRITE);
  // Nothing starts before the first load or outside standard mode
  assign rw_hit = q.loaded && q.std && ((cmd == CMD_READ) || wr_cmd);
  assign new_mask = (wr_cmd && q.cfg[WB_BIT]) ? '0 : bl_mask(q.cfg);
  assign g_start = rw_hit ? i_pins.addr[COL_W-1:0] : q.start;
  assign g_cnt = rw_hit ? '0 : q.cnt;
  assign g_mask = rw_hit ? new_mask : q.bmask;

  sdmrb_col_gen i_sdmrb_col_gen (
    .i_start(g_start),
    .i_cnt(g_cnt),
    .i_mask(g_mask),
    .i_ilv(q.cfg[BT_BIT]),
    .o_col(g_col)
  );

  always_comb begin
    d = q;
    beat = '0;
    beat_wr = 1'b0;
    if (cmd == CMD_LOAD && i_pins.ba == BA_BASE) begin
      d.cfg = {i_pins.ba, i_pins.addr};
      d.loaded = 1'b1;
    end else if (cmd == CMD_LOAD && i_pins.ba == BA_EXT) begin
      d.ext = {i_pins.ba, i_pins.addr};
    end
    if (rw_hit) begin
      beat.valid = 1'b1;
      beat.col = g_col;
      beat_wr = wr_cmd;
      d.wr = wr_cmd;
      d.start = i_pins.addr[COL_W-1:0];
      d.bmask = new_mask;
      d.page = (new_mask == PAGE_MASK) && (new_mask != '0);
      d.cnt = 10'h001 & new_mask;
      d.st = (new_mask == '0) ? ST_IDLE : ST_BURST;
    end else if (q.st == ST_BURST) begin
      // A terminate stops the beat at its own edge
      if (cmd == CMD_TERM || !q.std) begin
        d.st = ST_IDLE;
      end else begin
        beat.valid = 1'b1;
        beat.col = g_col;
        beat_wr = q.wr;
        d.cnt = COL_W'(q.cnt + 10'h001) & q.bmask;
        if (!q.page && q.cnt == q.bmask) begin
          d.st = ST_IDLE;
        end
      end
    end
    rbeat.valid = beat.valid && !beat_wr;
    rbeat.col = beat.col;
    d.p1 = rbeat;
    d.p2 = q.p1;
    // Pipeline tap picks the beat for edge r+q-1
    unique case (q.lat)
      LAT_CYC_1: d.rd = rbeat;
      LAT_CYC_2: d.rd = q.p1;
      default: d.rd = q.p2;
    endcase
    d.dq_oe_n = !d.rd.valid;
    d.wb.valid = beat.valid && beat_wr;
    d.wb.col = beat.col;
    d.blen = COL_W'(bl_mask(d.cfg) + 10'h001);
    d.lat = lat_dec(d.cfg);
    d.std = (d.cfg[MODE_LSB +: MODE_W] == MODE_STD);
    d.busy = (d.st == ST_BURST);
  end

  // Reset clears the loaded flag; contents count as unknown until loaded
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
      q.cfg <= CFG_RST;
      q.dq_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign o_cfg = q.cfg;
  assign o_ext_cfg = q.ext;
  assign o_cfg_loaded = q.loaded;
  assign o_burst_len = q.blen;
  assign o_cas_lat = q.lat;
  assign o_std_mode = q.std;
  assign o_busy = q.busy;
  assign o_rd = q.rd;
  assign o_dq_oe_n = q.dq_oe_n;
  assign o_wr = q.wb;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  cfg_hold_a: assert property (
    !(cmd == CMD_LOAD && i_pins.ba == BA_BASE) |=> $stable(o_cfg))
    else $error("base config changed without a load");

  cfg_load_a: assert property (
    (cmd == CMD_LOAD && i_pins.ba == BA_BASE)
      |=> (o_cfg[ADDR_W-1:0] == $past(i_pins.addr)) && o_cfg_loaded)
    else $error("base load did not store the address bits");

  ext_load_a: assert property (
    (cmd == CMD_LOAD && i_pins.ba == BA_EXT)
      |=> $stable(o_cfg) && (o_ext_cfg[ADDR_W-1:0] == $past(i_pins.addr)))
    else $error("extended load went to the wrong register");

  len_decode_a: assert property (
    (o_cfg[BL_LSB +: BL_W] == BL_8) |-> (o_burst_len == 10'h008))
    else $error("length eight decoded wrongly");

  lat_one_a: assert property (
    (rw_hit && !wr_cmd && q.lat == LAT_CYC_1)
      |=> o_rd.valid && !o_dq_oe_n && (o_rd.col == $past(i_pins.addr[COL_W-1:0])))
    else $error("latency one read not presented at once");

  lat_three_a: assert property (
    (rw_hit && !wr_cmd && q.lat == LAT_CYC_3)
      |-> ##3 o_rd.valid && !o_dq_oe_n && (o_rd.col == $past(i_pins.addr[COL_W-1:0], 3)))
    else $error("latency three read misplaced");

  wr_single_a: assert property (
    (rw_hit && wr_cmd && q.cfg[WB_BIT]) |=> o_wr.valid && !o_busy)
    else $error("single write mode still bursting");

  seq_step_a: assert property (
    (beat.valid && q.st == ST_BURST && !rw_hit && !q.cfg[BT_BIT] && $past(beat.valid))
      |-> ((COL_W'(beat.col - $past(beat.col)) & q.bmask) == 10'h001))
    else $error("sequential burst did not step by one");

  // Block bits must match the previous beat of the same burst
  block_wrap_a: assert property (
    (beat.valid && q.st == ST_BURST && !rw_hit && $past(beat.valid))
      |-> (((beat.col ^ $past(beat.col)) & ~q.bmask) == 10'h000))
    else $error("burst left its aligned block");

  mode_gate_a: assert property (
    !o_std_mode |=> !o_wr.valid && !o_busy)
    else $error("access started outside standard mode");

  len_one_a: assert property (
    (o_cfg_loaded && o_cfg[BL_LSB +: BL_W] == BL_1) |-> (o_burst_len == 10'h001))
    else $error("length one decoded wrongly");

  len_two_a: assert property (
    (o_cfg_loaded && o_cfg[BL_LSB +: BL_W] == BL_2) |-> (o_burst_len == 10'h002))
    else $error("length two decoded wrongly");

  len_four_a: assert property (
    (o_cfg_loaded && o_cfg[BL_LSB +: BL_W] == BL_4) |-> (o_burst_len == 10'h004))
    else $error("length four decoded wrongly");

  len_page_a: assert property (
    (o_cfg_loaded && o_cfg[BL_LSB +: BL_W] == BL_PAGE && !o_cfg[BT_BIT])
      |-> (o_burst_len == COL_W'(PAGE_LEN)))
    else $error("full page length decoded wrongly");

  lat_decode_a: assert property (
    (o_cfg_loaded && o_cfg[LAT_LSB +: LAT_W] == LAT_2) |-> (o_cas_lat == LAT_CYC_2))
    else $error("latency two decoded wrongly");

  lat_two_a: assert property (
    (rw_hit && !wr_cmd && q.lat == LAT_CYC_2)
      |-> ##2 o_rd.valid && !o_dq_oe_n && (o_rd.col == $past(i_pins.addr[COL_W-1:0], 2)))
    else $error("latency two read misplaced");

  wr_first_a: assert property (
    (rw_hit && wr_cmd) |=> o_wr.valid && (o_wr.col == $past(i_pins.addr[COL_W-1:0])))
    else $error("first write beat missing or misplaced");

  single_len_a: assert property (
    (rw_hit && o_cfg[BL_LSB +: BL_W] == BL_1) |=> !o_busy)
    else $error("length one access kept bursting");

  mode_decode_a: assert property (
    o_cfg_loaded |-> (o_std_mode == (o_cfg[MODE_LSB +: MODE_W] == MODE_STD)))
    else $error("operating mode decoded wrongly");

  term_stop_a: assert property (
    (o_busy && cmd == CMD_TERM) |=> !o_busy && !o_wr.valid)
    else $error("terminate did not stop the burst");

  burst_end_a: assert property (
    (o_busy && !q.page && q.cnt == q.bmask && !rw_hit) |=> !o_busy)
    else $error("burst ran past its length");

  // Interleave steps differ by k xor k-1 whatever the start
  ilv_step_a: assert property (
    (beat.valid && q.st == ST_BURST && !rw_hit && q.cfg[BT_BIT] && $past(beat.valid))
      |-> (((beat.col ^ $past(beat.col)) & q.bmask)
           == ((q.cnt ^ COL_W'(q.cnt - 10'h001)) & q.bmask)))
    else $error("interleaved burst order wrong");

  oe_follow_a: assert property (
    o_dq_oe_n == !o_rd.valid)
    else $error("data drive enable out of step with read beat");

endmodule
`default_nettype wire

// *** hdl/sdmrb_pkg.sv ***
// Shared constants and carrier types of the SDRAM configuration and burst logic
package sdmrb_pkg;

  localparam int CFG_W = 15;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;

  // Field positions in the base configuration register
  localparam int BL_LSB = 0;
  localparam int BL_W = 3;
  localparam int BT_BIT = 3;
  localparam int LAT_LSB = 4;
  localparam int LAT_W = 3;
  localparam int MODE_LSB = 7;
  localparam int MODE_W = 2;
  localparam int WB_BIT = 9;

  localparam logic [CFG_W-1:0] CFG_RST = 15'h0000;

  // Burst length codes
  localparam logic [BL_W-1:0] BL_1 = 3'h0;
  localparam logic [BL_W-1:0] BL_2 = 3'h1;
  localparam logic [BL_W-1:0] BL_4 = 3'h2;
  localparam logic [BL_W-1:0] BL_8 = 3'h3;
  localparam logic [BL_W-1:0] BL_PAGE = 3'h7;

  // Read latency codes and their cycle counts
  localparam logic [LAT_W-1:0] LAT_1 = 3'h1;
  localparam logic [LAT_W-1:0] LAT_2 = 3'h2;
  localparam logic [LAT_W-1:0] LAT_3 = 3'h3;
  localparam logic [1:0] LAT_CYC_1 = 2'h1;
  localparam logic [1:0] LAT_CYC_2 = 2'h2;
  localparam logic [1:0] LAT_CYC_3 = 2'h3;

  localparam logic [MODE_W-1:0] MODE_STD = 2'h0;

  // Bank-address selection during a load_config_command
  localparam logic [1:0] BA_BASE = 2'h0;
  localparam logic [1:0] BA_EXT = 2'h2;

  // Command codes as {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_LOAD = 4'h0;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_ROW_OPEN = 4'h3;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_TERM = 4'h6;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } sdmrb_pins_t;

  typedef struct packed {
    logic valid;
    logic [COL_W-1:0] col;
  } sdmrb_beat_t;

  typedef enum logic {ST_IDLE, ST_BURST} sdmrb_st_t;

endpackage
